// [rtl/buck_fault_and_enable_logic.sv]
// Purpose: Protection, power-good and enable supervision for two rails
// Assumes: Comparators arrive asynchronously; registers on a local port
// Notes:   Channel one feedback drives both rails in two-phase mode
`timescale 1ns/1ps
`default_nettype none
module buck_fault_and_enable_logic
(
  input  wire logic        clk,            // Core clock 10 MHz
  input  wire logic        resetn,         // Async reset, active low
  input  wire logic        regWrite,       // Register write strobe
  input  wire logic        regRead,        // Register read strobe
  input  wire logic [7:0]  regAddr,        // Command code
  input  wire logic [15:0] regWdata,       // Write data
  output var  logic [15:0] regRdata,       // Read data, registered
  output var  logic        nvmStore,       // Scratchpad commit pulse
  input  wire logic [15:0] vinCode,        // Input voltage reading
  input  wire logic [1:0]  temp_sensor_in, // Rail temperature codes valid
  input  wire logic [15:0] tempCh1,        // Rail one temperature
  input  wire logic [15:0] tempCh2,        // Rail two temperature
  input  wire logic [1:0]  overvoltage_threshold,  // OV comparators
  input  wire logic [1:0]  undervoltage_threshold, // UV comparators
  input  wire logic [1:0]  pgWinHi,        // Above window, one per rail
  input  wire logic [1:0]  pgWinLo,        // Below window
  input  wire logic        dieHot,         // Die at shutdown limit
  input  wire logic        dieCool,        // Die cooled to restart
  input  wire logic [1:0]  rail_control_pin, // Control pins
  output var  logic [1:0]  high_side_gate, // High-side enable
  output var  logic [1:0]  low_side_gate,  // Low-side force on
  output var  logic [1:0]  pwmRun,         // Modulator running
  output var  logic [1:0]  deadLong,       // Longer dead time
  output var  logic [1:0]  power_ok_out,   // Power good
  output var  logic [1:0]  pgLevelSel,     // Window selection to analog
  output var  logic [1:0]  otFault,        // Overtemp fault
  output var  logic [1:0]  otWarn,         // Overtemp warning
  output var  logic        vinOk           // Input above lockout
);
  // ==========================================================
  // Register storage
  logic [15:0] vinOn, vinOff, otFaultLim, otWarnLim, scratch, deadSel;
  logic [15:0] pgOn, pgOff, modeCfg;
  logic [7:0]  ocResp, onoffCfg, operation;
  logic [15:0] next_vinOn, next_vinOff, next_otFaultLim, next_otWarnLim;
  logic [15:0] next_scratch, next_deadSel, next_pgOn, next_pgOff;
  logic [15:0] next_modeCfg, next_regRdata;
  logic [7:0]  next_ocResp, next_onoffCfg, next_operation;
  logic        next_nvmStore;
  logic [7:0]  statusByte;

  // Write decode and read mux
  always_comb
  begin
    next_vinOn = vinOn;
    next_vinOff = vinOff;
    next_otFaultLim = otFaultLim;
    next_otWarnLim = otWarnLim;
    next_scratch = scratch;
    next_deadSel = deadSel;
    next_pgOn = pgOn;
    next_pgOff = pgOff;
    next_modeCfg = modeCfg;
    next_ocResp = ocResp;
    next_onoffCfg = onoffCfg;
    next_operation = operation;
    next_nvmStore = 1'b0;
    next_regRdata = regRdata;
    if (regWrite)
    begin
      case (regAddr)
        buck_prot_pkg::OFS_VIN_ON:
          next_vinOn = (regWdata > buck_prot_pkg::VIN_ON_MAX)
                       ? buck_prot_pkg::VIN_ON_MAX : regWdata;
        buck_prot_pkg::OFS_VIN_OFF:
          next_vinOff = (regWdata < buck_prot_pkg::VIN_OFF_MIN)
                        ? buck_prot_pkg::VIN_OFF_MIN : regWdata;
        buck_prot_pkg::OFS_OT_FAULT: next_otFaultLim = regWdata;
        buck_prot_pkg::OFS_OT_WARN:  next_otWarnLim = regWdata;
        buck_prot_pkg::OFS_SCRATCH:
        begin
          next_scratch  = regWdata;
          next_nvmStore = 1'b1;
        end
        buck_prot_pkg::OFS_DEADTIME: next_deadSel = regWdata;
        buck_prot_pkg::OFS_PG_ON:    next_pgOn = regWdata;
        buck_prot_pkg::OFS_PG_OFF:   next_pgOff = regWdata;
        buck_prot_pkg::OFS_MODE_CFG: next_modeCfg = regWdata;
        buck_prot_pkg::OFS_OC_RESP:  next_ocResp = regWdata[7:0];
        buck_prot_pkg::OFS_ONOFF_CFG: next_onoffCfg = regWdata[7:0];
        buck_prot_pkg::OFS_OPERATION: next_operation = regWdata[7:0];
        default: next_nvmStore = 1'b0;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        buck_prot_pkg::OFS_VIN_ON:    next_regRdata = vinOn;
        buck_prot_pkg::OFS_VIN_OFF:   next_regRdata = vinOff;
        buck_prot_pkg::OFS_OT_FAULT:  next_regRdata = otFaultLim;
        buck_prot_pkg::OFS_OT_WARN:   next_regRdata = otWarnLim;
        buck_prot_pkg::OFS_SCRATCH:   next_regRdata = scratch;
        buck_prot_pkg::OFS_DEADTIME:  next_regRdata = deadSel;
        buck_prot_pkg::OFS_PG_ON:     next_regRdata = pgOn;
        buck_prot_pkg::OFS_PG_OFF:    next_regRdata = pgOff;
        buck_prot_pkg::OFS_MODE_CFG:  next_regRdata = modeCfg;
        buck_prot_pkg::OFS_OC_RESP:   next_regRdata = {8'h00, ocResp};
        buck_prot_pkg::OFS_ONOFF_CFG: next_regRdata = {8'h00, onoffCfg};
        buck_prot_pkg::OFS_OPERATION: next_regRdata = {8'h00, operation};
        buck_prot_pkg::OFS_STATUS:    next_regRdata = {8'h00, statusByte};
        default:                      next_regRdata = 16'h0000;
      endcase
    end
  end

  // Register the map
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vinOn      <= buck_prot_pkg::RST_VIN_ON;
      vinOff     <= buck_prot_pkg::RST_VIN_OFF;
      otFaultLim <= buck_prot_pkg::RST_OT_FAULT;
      otWarnLim  <= buck_prot_pkg::RST_OT_WARN;
      scratch    <= 16'h0000;
      deadSel    <= 16'h0000;
      pgOn       <= buck_prot_pkg::RST_PG_ON;
      pgOff      <= buck_prot_pkg::RST_PG_OFF;
      modeCfg    <= 16'h0000;
      ocResp     <= buck_prot_pkg::RST_OC_RESP;
      onoffCfg   <= buck_prot_pkg::RST_ONOFF_CFG;
      operation  <= buck_prot_pkg::RST_OPERATION;
      nvmStore   <= 1'b0;
      regRdata   <= 16'h0000;
    end
    else
    begin
      vinOn      <= next_vinOn;
      vinOff     <= next_vinOff;
      otFaultLim <= next_otFaultLim;
      otWarnLim  <= next_otWarnLim;
      scratch    <= next_scratch;
      deadSel    <= next_deadSel;
      pgOn       <= next_pgOn;
      pgOff      <= next_pgOff;
      modeCfg    <= next_modeCfg;
      ocResp     <= next_ocResp;
      onoffCfg   <= next_onoffCfg;
      operation  <= next_operation;
      nvmStore   <= next_nvmStore;
      regRdata   <= next_regRdata;
    end
  end

  // ==========================================================
  // Synchronise analog comparators
  logic [1:0] ovS, uvS, hiS, loS, pinS;
  logic       hotS, coolS;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gSync
      sync3 uOv (.clk(clk), .resetn(resetn),
                 .din(overvoltage_threshold[g]), .dout(ovS[g]));
      sync3 uUv (.clk(clk), .resetn(resetn),
                 .din(undervoltage_threshold[g]), .dout(uvS[g]));
      sync3 uHi (.clk(clk), .resetn(resetn),
                 .din(pgWinHi[g]), .dout(hiS[g]));
      sync3 uLo (.clk(clk), .resetn(resetn),
                 .din(pgWinLo[g]), .dout(loS[g]));
      sync3 uPin (.clk(clk), .resetn(resetn),
                  .din(rail_control_pin[g]), .dout(pinS[g]));
    end
  endgenerate
  sync3 uHot (.clk(clk), .resetn(resetn), .din(dieHot), .dout(hotS));
  sync3 uCool (.clk(clk), .resetn(resetn), .din(dieCool), .dout(coolS));

  // ==========================================================
  // Input lockout with hysteresis and thermal latch
  logic vinOkR, next_vinOk, thermR, next_therm;
  always_comb
  begin
    next_vinOk = vinOkR;
    if (vinCode >= vinOn)
      next_vinOk = 1'b1;
    else if (vinCode < vinOff)
      next_vinOk = 1'b0;
    next_therm = thermR;
    if (hotS)
      next_therm = 1'b1;
    else if (coolS)
      next_therm = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vinOkR <= 1'b0;
      thermR <= 1'b0;
    end
    else
    begin
      vinOkR <= next_vinOk;
      thermR <= next_therm;
    end
  end
  assign vinOk = vinOkR;

  // ==========================================================
  // Enable source selection
  logic       twoPhase, pinOn0, pinOn1, cmdOn;
  logic [1:0] pinOn, railEn;
  assign twoPhase = modeCfg[buck_prot_pkg::MODE_TWOPH_BIT];
  assign cmdOn    = operation[buck_prot_pkg::OPER_ON_BIT];
  assign pinOn0   = pinS[0] ~^ onoffCfg[buck_prot_pkg::ONOFF_POL_BIT];
  assign pinOn1   = pinS[1] ~^ onoffCfg[buck_prot_pkg::ONOFF_POL_BIT];
  assign pinOn    = {twoPhase ? pinOn0 : pinOn1, pinOn0};

  // Pin, command, both or neither gate each rail
  always_comb
  begin
    railEn = 2'b00;
    case ({onoffCfg[buck_prot_pkg::ONOFF_PIN_BIT],
           onoffCfg[buck_prot_pkg::ONOFF_CMD_BIT]})
      2'b10: railEn = pinOn;
      2'b01: railEn = {cmdOn, cmdOn};
      2'b11: railEn = pinOn & {cmdOn, cmdOn};
      default: railEn = 2'b11;
    endcase
    railEn = railEn & {vinOkR, vinOkR};
  end

  // ==========================================================
  // Per-channel protection machines
  logic [1:0] hiEn, loF, run, flt, ovIn, uvIn, winIn;
  assign winIn = ~hiS & ~loS;
  assign ovIn  = twoPhase ? {ovS[0], ovS[0]} : ovS;
  assign uvIn  = twoPhase ? {uvS[0], uvS[0]} : uvS;
  generate
    for (g = 0; g < 2; g++)
    begin : gCh
      rail_protect uRail
      (
        .clk      (clk),
        .resetn   (resetn),
        .enable   (railEn[g]),
        .overVolt (ovIn[g]),
        .underVolt(uvIn[g]),
        .inWindow (twoPhase ? winIn[0] : winIn[g]),
        .thermStop(thermR),
        .latchOff (ocResp[buck_prot_pkg::OCRESP_LATCH_BIT]),
        .highEn   (hiEn[g]),
        .lowForce (loF[g]),
        .running  (run[g]),
        .faulted  (flt[g])
      );
    end
  endgenerate

  // ==========================================================
  // Outputs and power good
  logic [1:0] pgNext, otFNext, otWNext;
  logic [1:0] temp0, temp1;
  always_comb
  begin
    pgNext  = run & winIn & ~flt;
    if (twoPhase)
      pgNext = {1'b0, run[0] & winIn[0] & ~flt[0]};
    otFNext = {temp_sensor_in[1] && (tempCh2 >= otFaultLim),
               temp_sensor_in[0] && (tempCh1 >= otFaultLim)};
    otWNext = {temp_sensor_in[1] && (tempCh2 >= otWarnLim),
               temp_sensor_in[0] && (tempCh1 >= otWarnLim)};
  end
  assign temp0 = otFNext;
  assign temp1 = otWNext;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      power_ok_out   <= 2'b00;
      high_side_gate <= 2'b00;
      low_side_gate  <= 2'b00;
      pwmRun         <= 2'b00;
      deadLong       <= 2'b00;
      otFault        <= 2'b00;
      otWarn         <= 2'b00;
      pgLevelSel     <= 2'b00;
    end
    else
    begin
      power_ok_out   <= pgNext;
      high_side_gate <= hiEn;
      low_side_gate  <= loF;
      pwmRun         <= hiEn | loF;
      deadLong       <= {deadSel[buck_prot_pkg::DT_CH2_BIT],
                         deadSel[buck_prot_pkg::DT_CH1_BIT]};
      otFault        <= temp0;
      otWarn         <= temp1;
      pgLevelSel     <= pgOn[1:0];
    end
  end
  assign statusByte = {thermR, vinOkR, flt, otFault, power_ok_out};

  a_pg_needs_win: assert property (@(posedge clk) disable iff (!resetn)
    power_ok_out[0] |-> $past(winIn[0]) && $past(run[0]))
    else $error("power good outside window");
  a_pg_off_dis: assert property (@(posedge clk) disable iff (!resetn)
    !railEn[0] |=> ##1 !power_ok_out[0])
    else $error("power good while disabled");
  a_pin_mode: assert property (@(posedge clk) disable iff (!resetn)
    (onoffCfg[3:2] == 2'b10 && vinOkR) |-> railEn[0] == pinOn0)
    else $error("pin mode not followed");
  a_cmd_mode: assert property (@(posedge clk) disable iff (!resetn)
    (onoffCfg[3:2] == 2'b01 && vinOkR) |-> railEn[0] == cmdOn)
    else $error("command mode not followed");
  a_both_mode: assert property (@(posedge clk) disable iff (!resetn)
    (onoffCfg[3:2] == 2'b11 && vinOkR) |-> railEn[0] == (cmdOn && pinOn0))
    else $error("combined mode not followed");
  a_lockout: assert property (@(posedge clk) disable iff (!resetn)
    (vinCode < vinOff && vinCode < vinOn) |=> !vinOkR)
    else $error("lockout not entered");
  a_dead_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 deadLong == $past(deadSel[1:0]))
    else $error("dead time select mismatch");
  a_two_phase: assert property (@(posedge clk) disable iff (!resetn)
    twoPhase |-> ovIn[1] == ovS[0])
    else $error("two-phase sense not shared");
endmodule
`default_nettype wire

// [rtl/buck_prot_pkg.sv]
// Purpose: Shared constants for buck protection and enable supervision
// Assumes: 10 MHz core clock, registers written over a simple local port
// Notes:   Offsets with no printed value are chosen locally
package buck_prot_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_OC_RESP     = 8'h47;
  localparam logic [7:0] OFS_OT_FAULT    = 8'h4f;
  localparam logic [7:0] OFS_OT_WARN     = 8'h51;
  localparam logic [7:0] OFS_SCRATCH     = 8'hd0;
  localparam logic [7:0] OFS_DEADTIME    = 8'he5;
  localparam logic [7:0] OFS_VIN_ON      = 8'h35;
  localparam logic [7:0] OFS_VIN_OFF     = 8'h36;
  localparam logic [7:0] OFS_PG_ON       = 8'h5e;
  localparam logic [7:0] OFS_PG_OFF      = 8'h5f;
  localparam logic [7:0] OFS_ONOFF_CFG   = 8'h02;
  localparam logic [7:0] OFS_OPERATION   = 8'h01;
  localparam logic [7:0] OFS_MODE_CFG    = 8'hd1;
  localparam logic [7:0] OFS_STATUS      = 8'h79;
  // ==========================================================
  // Field positions
  localparam int ONOFF_PIN_BIT  = 3; // Pin participates
  localparam int ONOFF_CMD_BIT  = 2; // Command participates
  localparam int ONOFF_POL_BIT  = 1; // Pin active high when set
  localparam int OPER_ON_BIT    = 7;
  localparam int MODE_TWOPH_BIT = 0;
  localparam int OCRESP_LATCH_BIT = 7; // Set: latch off, clear: hiccup
  localparam int DT_CH1_BIT     = 0;
  localparam int DT_CH2_BIT     = 1;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_VIN_ON    = 16'h0010; // 16 V code
  localparam logic [15:0] RST_VIN_OFF   = 16'h0004; // 4 V code
  localparam logic [15:0] RST_OT_FAULT  = 16'h007d;
  localparam logic [15:0] RST_OT_WARN   = 16'h0073;
  localparam logic [15:0] RST_PG_ON     = 16'h0000;
  localparam logic [15:0] RST_PG_OFF    = 16'h0000;
  localparam logic [7:0]  RST_OC_RESP   = 8'h00;
  localparam logic [7:0]  RST_ONOFF_CFG = 8'h17;
  localparam logic [7:0]  RST_OPERATION = 8'h00;
  // Threshold limits in volt codes
  localparam logic [15:0] VIN_OFF_MIN   = 16'h0004;
  localparam logic [15:0] VIN_ON_MAX    = 16'h0010;
  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int HICCUP_US       = 1000;
  localparam int HICCUP_CYC      = HICCUP_US * (CLK_HZ / 1_000_000);
  localparam int SOFTSTART_US    = 600;
  localparam int SOFTSTART_CYC   = SOFTSTART_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // Channel protection states
  typedef enum logic [2:0] {
    CH_OFF   = 3'b000,
    CH_START = 3'b001,
    CH_RUN   = 3'b010,
    CH_OVDIS = 3'b011,
    CH_HICC  = 3'b100,
    CH_LATCH = 3'b101
  } ch_state_e;
endpackage

// [rtl/sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous input level
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sync3
(
  input  wire logic clk,    // Core clock
  input  wire logic resetn, // Async reset, active low
  input  wire logic din,    // Async level
  output var  logic dout    // Filtered level
);
  logic [2:0] stages;
  logic [2:0] next_stages;
  logic       next_dout;

  // Shift and filter
  always_comb
  begin
    next_stages = {stages[1:0], din};
    next_dout   = (stages[1] == stages[2]) ? stages[2] : dout;
  end

  // Register stages
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stages <= 3'b000;
      dout   <= 1'b0;
    end
    else
    begin
      stages <= next_stages;
      dout   <= next_dout;
    end
  end
endmodule
`default_nettype wire

// [rtl/rail_protect.sv]
// Purpose: One channel's protection state machine
// Assumes: Synchronised comparator levels
// Notes:   Identical instance per channel
`timescale 1ns/1ps
`default_nettype none
module rail_protect
(
  input  wire logic clk,        // Core clock
  input  wire logic resetn,     // Async reset, active low
  input  wire logic enable,     // Rail requested on
  input  wire logic overVolt,   // Overvoltage level
  input  wire logic underVolt,  // Undervoltage level
  input  wire logic inWindow,   // Output inside power-good window
  input  wire logic thermStop,  // Die shutdown active
  input  wire logic latchOff,   // Fault response latches off
  output var  logic highEn,     // High-side gate permitted
  output var  logic lowForce,   // Low-side held on
  output var  logic running,    // Regulating after start
  output var  logic faulted     // Set while in CH_OVDIS, CH_HICC or CH_LATCH
);
  buck_prot_pkg::ch_state_e state;
  buck_prot_pkg::ch_state_e next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;

  localparam logic [15:0] HICC_CNT =
    16'(buck_prot_pkg::HICCUP_CYC - 1);
  localparam logic [15:0] SS_CNT =
    16'(buck_prot_pkg::SOFTSTART_CYC - 1);

  // Next state
  always_comb
  begin
    next_state = state;
    next_timer = (timer != 16'h0000) ? timer - 16'h0001 : timer;
    case (state)
      buck_prot_pkg::CH_OFF:
        if (enable && !thermStop)
        begin
          next_state = buck_prot_pkg::CH_START;
          next_timer = SS_CNT;
        end
      buck_prot_pkg::CH_START:
        if (timer == 16'h0000)
          next_state = buck_prot_pkg::CH_RUN;
      buck_prot_pkg::CH_RUN:
        if (overVolt)
          next_state = buck_prot_pkg::CH_OVDIS;
        else if (underVolt)
        begin
          next_state = latchOff ? buck_prot_pkg::CH_LATCH
                                : buck_prot_pkg::CH_HICC;
          next_timer = HICC_CNT;
        end
      buck_prot_pkg::CH_OVDIS:
        if (inWindow && !overVolt)
          next_state = buck_prot_pkg::CH_RUN;
      buck_prot_pkg::CH_HICC:
        if (timer == 16'h0000)
        begin
          next_state = buck_prot_pkg::CH_START;
          next_timer = SS_CNT;
        end
      buck_prot_pkg::CH_LATCH:
        next_state = buck_prot_pkg::CH_LATCH;
      default:
        next_state = buck_prot_pkg::CH_OFF;
    endcase
    if (!enable || thermStop)
    begin
      next_state = buck_prot_pkg::CH_OFF;
      next_timer = 16'h0000;
    end
  end

  // Register state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= buck_prot_pkg::CH_OFF;
      timer <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Gate permissions
  assign highEn   = (state == buck_prot_pkg::CH_START) ||
                    (state == buck_prot_pkg::CH_RUN);
  assign lowForce = (state == buck_prot_pkg::CH_OVDIS);
  assign running  = (state == buck_prot_pkg::CH_RUN);
  assign faulted  = (state == buck_prot_pkg::CH_OVDIS) ||
                    (state == buck_prot_pkg::CH_HICC) ||
                    (state == buck_prot_pkg::CH_LATCH);

  // Fault conditions seen while regulating
  sequence s_ov_in_run;
    state == buck_prot_pkg::CH_RUN && overVolt && enable && !thermStop;
  endsequence
  sequence s_uv_in_run;
    state == buck_prot_pkg::CH_RUN && !overVolt && underVolt && enable
      && !thermStop;
  endsequence

  a_ov_low_on: assert property (@(posedge clk) disable iff (!resetn)
    s_ov_in_run |=> lowForce && !highEn)
    else $error("overvoltage did not force low side");

  a_uv_hiccup: assert property (@(posedge clk) disable iff (!resetn)
    s_uv_in_run ##0 !latchOff |=> state == buck_prot_pkg::CH_HICC)
    else $error("undervoltage did not enter hiccup");

  a_uv_latch: assert property (@(posedge clk) disable iff (!resetn)
    s_uv_in_run ##0 latchOff |=> state == buck_prot_pkg::CH_LATCH)
    else $error("undervoltage did not latch off");

  a_therm_off: assert property (@(posedge clk) disable iff (!resetn)
    thermStop |=> !highEn && !lowForce)
    else $error("gates active in thermal shutdown");
endmodule
`default_nettype wire

// [verif/rail_stage_model.sv]
// Purpose: Far-side output stage and window comparators
// Assumes: Output sits below the window unless switching or overshoot is forced
// Notes:   Overshoot is forced by the bench
`timescale 1ns/1ps
`default_nettype none
module rail_stage_model
(
  input  wire logic [1:0] pwmRun, // Modulators running
  input  wire logic [1:0] ovReq,  // Forced overshoot
  output var  logic [1:0] winHi,  // Above window
  output var  logic [1:0] winLo   // Below window
);
  // Window levels follow overshoot and switching
  assign {winHi, winLo} = {ovReq, ~pwmRun & ~ovReq};
endmodule
`default_nettype wire

// [verif/buck_fault_and_enable_logic_tb_top.sv]
// Purpose: Self-checking bench for buck fault and enable logic
// Assumes: Inputs move on falling edges
// Notes:   Soft start and hiccup are waited out in full
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module buck_fault_and_enable_logic_tb_top;
  logic        clk = 0, resetn = 0, regWrite = 0, regRead = 0, dieHot = 0;
  logic        dieCool = 1, vok, nvs;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000, vinCode = 16'h0020, regRdata;
  logic [15:0] tempCh1 = 16'h0000, tempCh2 = 16'h0000;
  logic [1:0]  ovReq = 2'h0, uv = 2'h0, pin = 2'h0, tv = 2'h0, hi, lo;
  logic [1:0]  hs, ls, run, dl, pg, otf, otw, pgs;
  int          n_errors = 0, n_compared = 0;
  buck_fault_and_enable_logic buck_fault_and_enable_logic_i
  (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .nvmStore(nvs), .vinCode(vinCode), .temp_sensor_in(tv), .tempCh1(tempCh1),
   .tempCh2(tempCh2), .overvoltage_threshold(ovReq), .dieHot(dieHot),
   .undervoltage_threshold(uv), .pgWinHi(hi), .pgWinLo(lo),
   .dieCool(dieCool), .rail_control_pin(pin), .high_side_gate(hs),
   .low_side_gate(ls), .pwmRun(run), .deadLong(dl), .power_ok_out(pg),
   .pgLevelSel(pgs), .otFault(otf), .otWarn(otw), .vinOk(vok));
  rail_stage_model rail_stage_model_i
  (.pwmRun(run), .ovReq(ovReq), .winHi(hi), .winLo(lo));
  // Clock and watchdog
  initial forever #50 clk = ~clk;
  initial #8_000_000 tally_and_finish(1);
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(negedge clk);
    regWrite = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clk);
    regRead = 0;
    `CHK(regRdata, e)
  endtask
  task automatic tally_and_finish(input int late);
    n_errors += late;
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_regs;
    wr(8'h35, 16'hffff);
    rd(8'h35, 16'h0010);
    wr(8'h36, 16'h0001);
    rd(8'h36, 16'h0004);
    `CHK(vok, 1'b1)
    vinCode = 16'h0003;
    cyc(2);
    `CHK(vok, 1'b0)
    vinCode = 16'h0008;
    cyc(2);
    `CHK(vok, 1'b0)
    vinCode = 16'h0020;
    cyc(2);
    `CHK(vok, 1'b1)
    wr(8'hd0, 16'ha5c3);
    `CHK(nvs, 1'b1)
    rd(8'hd0, 16'ha5c3);
    `CHK(nvs, 1'b0)
    rd(8'h20, 16'h0000);
    wr(8'h5e, 16'h0002);
    wr(8'h5f, 16'h0001);
    rd(8'h5f, 16'h0001);
    `CHK(pgs, 2'h2)
    wr(8'he5, 16'h0002);
    {tv, tempCh1, tempCh2} = {2'h3, 16'h007d, 16'h0074};
    cyc(4);
    `CHK({dl, otf, otw}, 6'h27)
    rd(8'h79, 16'h0044);
  endtask
  task automatic t_mode(input logic [15:0] c, o, input logic [1:0] p, e);
    wr(8'h02, c);
    wr(8'h01, o);
    pin = p;
    cyc(6100);
    `CHK({run, pg}, {e, e})
  endtask
  task automatic t_ov;
    ovReq = 2'h1;
    cyc(8);
    `CHK({hs, ls, pg}, 6'h26)
    wr(8'hd1, 16'h0001);
    cyc(8);
    `CHK({hs, ls}, 4'h3)
    {ovReq, dieHot, dieCool} = 4'h2;
    cyc(8);
    `CHK({hs, ls, run}, 6'h00)
    {dieHot, dieCool} = 2'h1;
    cyc(8);
    `CHK({run, pg}, 4'hc)
  endtask
  task automatic t_uv(input logic [15:0] r, input logic [1:0] e);
    wr(8'h47, r);
    cyc(6100);
    uv = 2'h1;
    cyc(10);
    `CHK({hs, pg}, 4'h0)
    uv = 2'h0;
    cyc(16200);
    `CHK({run, pg}, {e, 1'b0, e[0]})
  endtask
  // Main sequence
  initial
  begin
    #200 resetn = 1;
    t_regs;
    t_mode(16'h001e, 16'h0080, 2'h0, 2'h0);
    t_mode(16'h001e, 16'h0080, 2'h3, 2'h3);
    t_mode(16'h0006, 16'h0080, 2'h0, 2'h3);
    t_mode(16'h0008, 16'h0000, 2'h0, 2'h3);
    t_ov;
    t_uv(16'h0000, 2'h3);
    t_uv(16'h0080, 2'h0);
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
